// ==== inc/gspl_defines.svh ====
// Constants of the galvo serial position link: timing, frame layout, codes and status fields
//
// What this block does
// - Generator drives the link clock, nominally 2 MHz, twenty cycles per frame.
// - Sync and data are captured on falling link clock edges; change them on rising.
// - One low sync pulse per frame, one cycle, during the frame's last bit.
// - Frame is 3-bit code, 16-bit unsigned position MSB first, even parity bit.
// - Three independent 20-bit channels X, Y, Z share one clock and sync.
// - Only code 001, 16-bit position follows, is sent on every channel.
// - Codes 000, 010 and 1xx are reserved and never sent.
// - Each status bit is captured on the falling edge of our own link clock.
// - Two-axis status, code 011: power, temp, in-field, X/Y ack, fixed 101, repeated.
// - Two-axis status parity is not checked; even parity is regenerated locally.
// - Three-axis status, code 001: ready, temp, tracking per axis; zero gaps; even parity.
// - Three-axis bits 3..1 report X/Y/Z link parity errors, bit 0 clock error.
`ifndef GSPL_DEFINES_SVH
`define GSPL_DEFINES_SVH

// Timing
`define GSPL_CLK_PERIOD_NS 20
`define GSPL_LINK_PERIOD_NS 500
`define GSPL_LINK_DIV (`GSPL_LINK_PERIOD_NS / `GSPL_CLK_PERIOD_NS)

// Frame layout, bit 19 is sent first
`define GSPL_FRAME_BITS 20
`define GSPL_POS_BITS 16
`define GSPL_CODE_MSB 19
`define GSPL_CODE_LSB 17
`define GSPL_WORD_MSB 16
`define GSPL_WORD_LSB 1
`define GSPL_PAR_BIT 0
`define GSPL_CODE_SLOTS 3

// Control codes
`define GSPL_CODE_POS16 3'h1
`define GSPL_CODE_ST2AXIS 3'h3
`define GSPL_CODE_ST3AXIS 3'h1

// Status word fields
`define GSPL_ST2_ACK_X 12
`define GSPL_ST2_ACK_Y 11
`define GSPL_ST3_RDY_X 15
`define GSPL_ST3_RDY_Y 11
`define GSPL_ST3_RDY_Z 7
`define GSPL_ST3_PERR_MSB 3
`define GSPL_ST3_PERR_LSB 1
`define GSPL_ST3_CLKERR 0

`endif

// ==== inc/gspl_pkg.sv ====
// Types and frame helpers of the galvo serial position link
`include "gspl_defines.svh"
package gspl_pkg;

  typedef enum logic [1:0] {
    GSPL_FMT_NONE,
    GSPL_FMT_2AXIS,
    GSPL_FMT_3AXIS
  } gspl_fmt_t;

  typedef enum logic [1:0] {
    GSPL_ST_RESET,
    GSPL_ST_RUN
  } gspl_state_t;

  // Builds one position frame with its even parity bit
  function automatic logic [19:0] gspl_build_frame(input logic [2:0] code, input logic [15:0] pos);
    gspl_build_frame = {code, pos, ^{code, pos}};
  endfunction

  // Classifies a received status code
  function automatic gspl_fmt_t gspl_status_fmt(input logic [2:0] code);
    if (code == `GSPL_CODE_ST2AXIS) begin
      gspl_status_fmt = GSPL_FMT_2AXIS;
    end else if (code == `GSPL_CODE_ST3AXIS) begin
      gspl_status_fmt = GSPL_FMT_3AXIS;
    end else begin
      gspl_status_fmt = GSPL_FMT_NONE;
    end
  endfunction

endpackage

// ==== src/gspl_status_rx.sv ====
// Status frame receiver of the galvo serial position link
`timescale 1ns/100ps
`default_nettype none
`include "gspl_defines.svh"

module gspl_status_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample,
  input wire logic frame_end,
  input wire logic bit_in,
  output logic [15:0] status_word,
  output var gspl_pkg::gspl_fmt_t status_fmt,
  output logic status_valid,
  output logic status_code_err,
  output logic status_parity_err,
  output logic status_parity_gen,
  output logic [1:0] pos_ack,
  output logic [2:0] servo_ready,
  output logic [2:0] head_parity_err,
  output logic head_clock_err
);

  // ----------------------------------------
  // Shift register
  // ----------------------------------------
  logic [19:0] sh_q;
  logic [19:0] frame_w;
  gspl_pkg::gspl_fmt_t fmt_w;

  assign frame_w = {sh_q[`GSPL_FRAME_BITS-2:0], bit_in};
  assign fmt_w = gspl_pkg::gspl_status_fmt(frame_w[`GSPL_CODE_MSB:`GSPL_CODE_LSB]);

  // Bits enter in the order sent, code first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 20'h00000;
    end else if (sample) begin
      sh_q <= frame_w;
    end
  end

  // ----------------------------------------
  // Frame evaluation
  // ----------------------------------------
  // Results stand until the next frame end; valid pulses one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_valid <= 1'b0;
      status_word <= 16'h0000;
      status_fmt <= gspl_pkg::GSPL_FMT_NONE;
      status_code_err <= 1'b0;
      status_parity_err <= 1'b0;
      status_parity_gen <= 1'b0;
    end else begin
      status_valid <= sample && frame_end;
      if (sample && frame_end) begin
        status_word <= frame_w[`GSPL_WORD_MSB:`GSPL_WORD_LSB];
        status_fmt <= fmt_w;
        status_code_err <= (fmt_w == gspl_pkg::GSPL_FMT_NONE);
        // Two-axis heads send no real parity, so only three-axis frames are checked
        status_parity_err <= (fmt_w == gspl_pkg::GSPL_FMT_3AXIS) && (^frame_w);
        status_parity_gen <= ^frame_w[`GSPL_CODE_MSB:`GSPL_WORD_LSB];
      end
    end
  end

  // Decoded fields, updated only from frames of the matching format
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ack <= 2'h0;
      servo_ready <= 3'h0;
      head_parity_err <= 3'h0;
      head_clock_err <= 1'b0;
    end else if (sample && frame_end) begin
      if (fmt_w == gspl_pkg::GSPL_FMT_2AXIS) begin
        pos_ack <= {frame_w[`GSPL_ST2_ACK_X+`GSPL_WORD_LSB], frame_w[`GSPL_ST2_ACK_Y+`GSPL_WORD_LSB]};
      end
      if (fmt_w == gspl_pkg::GSPL_FMT_3AXIS && !(^frame_w)) begin
        servo_ready <= {frame_w[`GSPL_ST3_RDY_X+`GSPL_WORD_LSB], frame_w[`GSPL_ST3_RDY_Y+`GSPL_WORD_LSB],
                        frame_w[`GSPL_ST3_RDY_Z+`GSPL_WORD_LSB]};
        head_parity_err <= frame_w[`GSPL_ST3_PERR_MSB+`GSPL_WORD_LSB:`GSPL_ST3_PERR_LSB+`GSPL_WORD_LSB];
        head_clock_err <= frame_w[`GSPL_ST3_CLKERR+`GSPL_WORD_LSB];
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_ST2_NO_PARITY_ERR: assert property (@(posedge clk) disable iff (!rst_n)
    (status_valid && status_fmt == gspl_pkg::GSPL_FMT_2AXIS) |-> !status_parity_err)
    else $error("two-axis status flagged a parity error");

  AST_ST_CODE_ERR: assert property (@(posedge clk) disable iff (!rst_n)
    status_valid |-> (status_code_err == (status_fmt == gspl_pkg::GSPL_FMT_NONE)))
    else $error("code error does not match the status format");

  AST_ST3_PARITY: assert property (@(posedge clk) disable iff (!rst_n)
    (sample && frame_end && fmt_w == gspl_pkg::GSPL_FMT_3AXIS) |=> (status_parity_err == $past(^frame_w)))
    else $error("three-axis parity check wrong");

endmodule
`default_nettype wire

// ==== src/gspl_link_top.sv ====
// Position generator side of the galvo serial position link
`timescale 1ns/100ps
`default_nettype none
`include "gspl_defines.svh"

module gspl_link_top #(
  parameter int LINK_DIV = `GSPL_LINK_DIV
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] x_pos,
  input wire logic [15:0] y_pos,
  input wire logic [15:0] z_pos,
  input wire logic status_return_line,
  output logic link_clk,
  output logic frame_sync_n,
  output logic x_position_line,
  output logic y_position_line,
  output logic z_position_line,
  output logic pos_taken,
  output logic [15:0] status_word,
  output var gspl_pkg::gspl_fmt_t status_fmt,
  output logic status_valid,
  output logic status_code_err,
  output logic status_parity_err,
  output logic status_parity_gen,
  output logic [1:0] pos_ack,
  output logic [2:0] servo_ready,
  output logic [2:0] head_parity_err,
  output logic head_clock_err
);

  // ----------------------------------------
  // Derived counts
  // ----------------------------------------
  localparam logic [4:0] DIV_LAST = 5'(LINK_DIV - 1);
  // High phase is the longer half when the divide is odd
  localparam logic [4:0] HIGH_END = 5'((LINK_DIV + 1) / 2);
  // Two synchroniser stages after the falling edge
  localparam logic [4:0] SAMPLE_AT = 5'((LINK_DIV + 1) / 2 + 1);
  localparam logic [4:0] SLOT_LAST = 5'(`GSPL_FRAME_BITS - 1);
  localparam logic [4:0] CODE_LAST = 5'(`GSPL_CODE_SLOTS - 1);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Assertion is asynchronous, release is synchronous to clk
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // Run state
  // ----------------------------------------
  gspl_pkg::gspl_state_t state_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= gspl_pkg::GSPL_ST_RESET;
    end else begin
      case (state_q)
        gspl_pkg::GSPL_ST_RESET: state_q <= gspl_pkg::GSPL_ST_RUN;
        gspl_pkg::GSPL_ST_RUN: state_q <= gspl_pkg::GSPL_ST_RUN;
        default: state_q <= gspl_pkg::GSPL_ST_RESET;
      endcase
    end
  end

  // ----------------------------------------
  // Link clock divider
  // ----------------------------------------
  logic [4:0] div_q;
  logic [4:0] div_d;
  logic link_clk_q;
  logic bit_edge;

  assign bit_edge = (div_q == DIV_LAST);
  assign div_d = bit_edge ? 5'h00 : 5'(div_q + 5'h01);

  // Starts on its last count so the first edge after reset begins a frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= DIV_LAST;
    end else begin
      div_q <= div_d;
    end
  end

  // Rises at each bit start, falls mid bit where the head samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_clk_q <= 1'b0;
    end else begin
      link_clk_q <= (div_d < HIGH_END);
    end
  end

  // ----------------------------------------
  // Frame slot counter
  // ----------------------------------------
  logic [4:0] slot_q;
  logic frame_wrap;

  assign frame_wrap = bit_edge && (slot_q == SLOT_LAST);

  // Twenty bit slots per frame, no idle slot between frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= SLOT_LAST;
    end else if (bit_edge) begin
      slot_q <= frame_wrap ? 5'h00 : 5'(slot_q + 5'h01);
    end
  end

  // Sync is low for the last slot, so it is present on the 20th cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_sync_n <= 1'b1;
    end else if (bit_edge) begin
      frame_sync_n <= !(slot_q == SLOT_LAST - 5'h01);
    end
  end

  // ----------------------------------------
  // Position channels
  // ----------------------------------------
  logic [19:0] x_sh_q;
  logic [19:0] y_sh_q;
  logic [19:0] z_sh_q;

  // Positions are taken once per frame, so a word never tears mid frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_sh_q <= 20'h00000;
      y_sh_q <= 20'h00000;
      z_sh_q <= 20'h00000;
    end else if (frame_wrap) begin
      x_sh_q <= gspl_pkg::gspl_build_frame(`GSPL_CODE_POS16, x_pos);
      y_sh_q <= gspl_pkg::gspl_build_frame(`GSPL_CODE_POS16, y_pos);
      z_sh_q <= gspl_pkg::gspl_build_frame(`GSPL_CODE_POS16, z_pos);
    end else if (bit_edge) begin
      x_sh_q <= {x_sh_q[`GSPL_FRAME_BITS-2:0], 1'b0};
      y_sh_q <= {y_sh_q[`GSPL_FRAME_BITS-2:0], 1'b0};
      z_sh_q <= {z_sh_q[`GSPL_FRAME_BITS-2:0], 1'b0};
    end
  end

  // Acknowledges the load of x_pos, y_pos and z_pos
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_taken <= 1'b0;
    end else begin
      pos_taken <= frame_wrap;
    end
  end

  assign link_clk = link_clk_q;
  assign x_position_line = x_sh_q[`GSPL_CODE_MSB];
  assign y_position_line = y_sh_q[`GSPL_CODE_MSB];
  assign z_position_line = z_sh_q[`GSPL_CODE_MSB];

  // ----------------------------------------
  // Status input
  // ----------------------------------------
  logic st_meta_q;
  logic st_sync_q;
  logic st_sample;

  // Two stages against metastability; the sample point is delayed to match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_meta_q <= 1'b0;
      st_sync_q <= 1'b0;
    end else begin
      st_meta_q <= status_return_line;
      st_sync_q <= st_meta_q;
    end
  end

  // Picks the pin level as it was at our falling link clock edge
  assign st_sample = (div_q == SAMPLE_AT) && (state_q == gspl_pkg::GSPL_ST_RUN);

  gspl_status_rx u_status_rx (
    .clk(clk),
    .rst_n(rst_n),
    .sample(st_sample),
    .frame_end(slot_q == SLOT_LAST),
    .bit_in(st_sync_q),
    .status_word(status_word),
    .status_fmt(status_fmt),
    .status_valid(status_valid),
    .status_code_err(status_code_err),
    .status_parity_err(status_parity_err),
    .status_parity_gen(status_parity_gen),
    .pos_ack(pos_ack),
    .servo_ready(servo_ready),
    .head_parity_err(head_parity_err),
    .head_clock_err(head_clock_err)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Running parity of the X line, read only by a check
  logic par_acc_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      par_acc_q <= 1'b0;
    end else if (bit_edge) begin
      par_acc_q <= (slot_q == SLOT_LAST) ? 1'b0 : (par_acc_q ^ x_position_line);
    end
  end

  AST_LINK_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(link_clk_q) |-> ##25 $rose(link_clk_q))
    else $error("link clock period is not 25 cycles");

  AST_FRAME_LENGTH: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(frame_sync_n) |-> ##[500:500] $fell(frame_sync_n))
    else $error("frame is not twenty link cycles");

  AST_SYNC_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(frame_sync_n) |-> (!frame_sync_n)[*8] ##18 $rose(frame_sync_n))
    else $error("sync low is not one link cycle");

  AST_SYNC_SLOT: assert property (@(posedge clk) disable iff (!rst_n)
    !frame_sync_n |-> (slot_q == SLOT_LAST))
    else $error("sync low outside the last slot");

  AST_EDGE_ALIGN: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(x_position_line) || $changed(y_position_line) || $changed(z_position_line) ||
     $changed(frame_sync_n)) |-> $rose(link_clk_q))
    else $error("line changed away from the rising link edge");

  AST_CODE_001: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(link_clk_q) && slot_q <= CODE_LAST) |->
      ({x_position_line, y_position_line, z_position_line} == ((slot_q == CODE_LAST) ? 3'h7 : 3'h0)))
    else $error("control code is not 001");

  AST_EVEN_PARITY: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(link_clk_q) && slot_q == SLOT_LAST) |-> !(par_acc_q ^ x_position_line))
    else $error("x frame parity is not even");

  AST_POS_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    (bit_edge && slot_q == SLOT_LAST) |=> (pos_taken && x_sh_q[`GSPL_WORD_MSB:`GSPL_WORD_LSB] == $past(x_pos)))
    else $error("position not loaded at frame boundary");

  AST_STATUS_EVERY_FRAME: assert property (@(posedge clk) disable iff (!rst_n)
    status_valid |-> ##[500:500] status_valid)
    else $error("status not captured once per frame");

endmodule
`default_nettype wire

// ==== testbench/gspl_head_model.sv ====
// Scan head model: checks the position frames and returns status frames
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Scan head side of the position link
// ----------------------------------------
module gspl_head_model (
  input wire logic link_clk,
  input wire logic frame_sync_n,
  input wire logic x_line,
  input wire logic y_line,
  input wire logic z_line,
  input wire logic [19:0] st_frame,
  output var logic status_line,
  output var logic [19:0] rx_x,
  output var logic [19:0] rx_y,
  output var logic [19:0] rx_z,
  output var int rx_cnt,
  output var int drop_cnt
);
  logic [19:0] sh_x, sh_y, sh_z, st_cur;
  int slot;
  bit run;

  // A word with a wrong code or odd parity is still stored but counted in drop_cnt
  function automatic int bad_frame(input logic [19:0] f);
    return ((f[19:17] !== 3'h1) || (^f !== 1'b0)) ? 1 : 0;
  endfunction

  initial begin
    status_line = 1'b0;
    rx_cnt = 0;
    drop_cnt = 0;
    run = 1'b0;
    slot = 0;
    st_cur = 20'h0;
  end

  // Sync and data are taken on the falling link edge; sync low marks the last bit
  always @(negedge link_clk) begin
    sh_x = {sh_x[18:0], x_line};
    sh_y = {sh_y[18:0], y_line};
    sh_z = {sh_z[18:0], z_line};
    if (run && slot == 19) begin
      if (frame_sync_n !== 1'b0) begin
        drop_cnt += 3;
      end else begin
        rx_x = sh_x;
        rx_y = sh_y;
        rx_z = sh_z;
        drop_cnt += bad_frame(sh_x) + bad_frame(sh_y) + bad_frame(sh_z);
        rx_cnt++;
      end
    end
    if (frame_sync_n === 1'b0) begin
      run = 1'b1;
      slot = 19;
    end
  end

  // Status moves on the rising edge; before framing is known the pin toggles
  always @(posedge link_clk) begin
    if (!run) begin
      status_line = ~status_line;
    end else begin
      slot = (slot == 19) ? 0 : slot + 1;
      if (slot == 0) st_cur = st_frame;
      status_line = st_cur[19 - slot];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/gspl_link_top_test.sv ====
// Self-checking bench of the galvo serial position link
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module gspl_link_top_test;
  logic clk, nrst, status_return_line, link_clk, frame_sync_n, pos_taken;
  logic x_position_line, y_position_line, z_position_line;
  logic [15:0] x_pos, y_pos, z_pos, status_word;
  gspl_pkg::gspl_fmt_t status_fmt;
  logic status_valid, status_code_err, status_parity_err, status_parity_gen, head_clock_err;
  logic [1:0] pos_ack, exp_ack;
  logic [2:0] servo_ready, head_parity_err, exp_rdy, exp_hp;
  logic exp_ce, prev_lc;
  logic [3:0] prev_lines;
  logic [19:0] st_frame, rx_x, rx_y, rx_z;
  int rx_cnt, drop_cnt, err_total, n_tests, cyc;

  gspl_link_top #(.LINK_DIV(25)) dut (.clk(clk), .nrst(nrst), .x_pos(x_pos), .y_pos(y_pos),
    .z_pos(z_pos), .status_return_line(status_return_line), .link_clk(link_clk),
    .frame_sync_n(frame_sync_n), .x_position_line(x_position_line), .y_position_line(y_position_line),
    .z_position_line(z_position_line), .pos_taken(pos_taken), .status_word(status_word),
    .status_fmt(status_fmt), .status_valid(status_valid), .status_code_err(status_code_err),
    .status_parity_err(status_parity_err), .status_parity_gen(status_parity_gen), .pos_ack(pos_ack),
    .servo_ready(servo_ready), .head_parity_err(head_parity_err), .head_clock_err(head_clock_err));

  gspl_head_model head (.link_clk(link_clk), .frame_sync_n(frame_sync_n), .x_line(x_position_line),
    .y_line(y_position_line), .z_line(z_position_line), .st_frame(st_frame),
    .status_line(status_return_line), .rx_x(rx_x), .rx_y(rx_y), .rx_z(rx_z), .rx_cnt(rx_cnt),
    .drop_cnt(drop_cnt));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run needs about 13500 cycles; a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      end_sim;
    end
  end

  // Sync and lines may only move at a link rise, well away from the sampling fall
  always @(negedge clk) begin
    if (nrst === 1'b1 && {frame_sync_n, x_position_line, y_position_line, z_position_line} !== prev_lines)
      if (!(link_clk === 1'b1 && prev_lc === 1'b0)) check(20'h1, 20'h0);
    prev_lines = {frame_sync_n, x_position_line, y_position_line, z_position_line};
    prev_lc = link_clk;
  end

  // Bounded wait for status_valid (sel 0) or pos_taken (sel 1)
  task wait_for(input bit sel);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #2;
      k++;
    end while ((sel ? pos_taken : status_valid) !== 1'b1 && k < 1200);
    if (k >= 1200) check(20'h1, 20'h0);
  endtask

  task t_timing;
    int lo, hi, rises;
    logic lc;
    lo = 0;
    hi = 0;
    rises = 0;
    do begin
      @(posedge clk);
      #2;
    end while (frame_sync_n !== 1'b0 && cyc < 29000);
    lc = link_clk;
    repeat (500) begin
      @(posedge clk);
      #2;
      lo += (frame_sync_n === 1'b0);
      hi += (link_clk === 1'b1);
      rises += (link_clk === 1'b1 && lc === 1'b0);
      lc = link_clk;
    end
    check(20'(rises), 20'd20);
    check(20'(hi), 20'd260);
    check({19'h0, frame_sync_n}, 20'h0);
    check(20'(lo), 20'd25);
    $display("test link timing done");
  endtask

  task t_pos;
    logic [15:0] v [9];
    int c, k;
    v = '{16'h0000, 16'hffff, 16'h8001, 16'h1234, 16'h0001, 16'h7ffe, 16'hffff, 16'h0000, 16'ha5a5};
    for (int i = 0; i < 9; i += 3) begin
      wait_for(1'b1);
      x_pos = v[i];
      y_pos = v[i + 1];
      z_pos = v[i + 2];
      wait_for(1'b1);
      @(posedge clk);
      #2;
      check({19'h0, pos_taken}, 20'h0);
      c = rx_cnt;
      k = 0;
      while (rx_cnt == c && k < 600) begin
        @(posedge clk);
        k++;
      end
      check(rx_x, {3'h1, v[i], ^{3'h1, v[i]}});
      check(rx_y, {3'h1, v[i + 1], ^{3'h1, v[i + 1]}});
      check(rx_z, {3'h1, v[i + 2], ^{3'h1, v[i + 2]}});
    end
    check(20'(drop_cnt), 20'h0);
    $display("test position frames done");
  endtask

  task t_status(input logic [2:0] code, input logic [15:0] w, input logic bad);
    logic [1:0] ef;
    st_frame = {code, w, ^{code, w} ^ bad};
    wait_for(1'b0);
    wait_for(1'b0);
    ef = (code == 3'h3) ? gspl_pkg::GSPL_FMT_2AXIS : (code == 3'h1) ? gspl_pkg::GSPL_FMT_3AXIS :
      gspl_pkg::GSPL_FMT_NONE;
    if (code == 3'h1 && !bad) begin
      exp_rdy = {w[15], w[11], w[7]};
      exp_hp = {w[3], w[2], w[1]};
      exp_ce = w[0];
    end
    if (code == 3'h3) exp_ack = {w[12], w[11]};
    check({4'h0, status_word}, {4'h0, w});
    check({18'h0, status_fmt}, {18'h0, ef});
    check({19'h0, status_code_err}, {19'h0, ef == gspl_pkg::GSPL_FMT_NONE});
    check({19'h0, status_parity_err}, {19'h0, code == 3'h1 && bad});
    check({19'h0, status_parity_gen}, {19'h0, ^{code, w}});
    check({18'h0, pos_ack}, {18'h0, exp_ack});
    check({13'h0, servo_ready, head_parity_err, head_clock_err}, {13'h0, exp_rdy, exp_hp, exp_ce});
    $display("test status code %h done", code);
  endtask

  initial begin
    logic [2:0] rc [6];
    rc = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    nrst = 1'b0;
    x_pos = 16'h0;
    y_pos = 16'h0;
    z_pos = 16'h0;
    st_frame = 20'h0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    exp_ack = 2'h0;
    exp_rdy = 3'h0;
    exp_hp = 3'h0;
    exp_ce = 1'b0;
    prev_lines = 4'h0;
    prev_lc = 1'b0;
    repeat (12) @(posedge clk);
    #2;
    check({18'h0, link_clk, frame_sync_n}, 20'h1);
    nrst = 1'b1;
    t_timing;
    t_pos;
    t_status(3'h1, 16'hb6a9, 1'b0);
    t_status(3'h1, 16'h4956, 1'b1);
    t_status(3'h3, 16'h95ad, 1'b0);
    t_status(3'h3, 16'h6a52, 1'b1);
    for (int i = 0; i < 6; i++) t_status(rc[i], 16'h0f0f, 1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
